// File: cisl_defines.svh
`ifndef CISL_DEFINES_SVH
`define CISL_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (printed offsets) and byte addresses
// ----------------------------------------------------------------
`define CISL_IDX_FLAGS1    16'h0730
`define CISL_IDX_FLAGS2    16'h0731
`define CISL_IDX_RAW2      16'h0732
`define CISL_IDX_RAW1      16'h0733
`define CISL_IDX_MASK1     16'h0738
`define CISL_IDX_MASK2     16'h0739
`define CISL_ADDR_FLAGS1   14'h1CC0
`define CISL_ADDR_FLAGS2   14'h1CC4
`define CISL_ADDR_RAW2     14'h1CC8
`define CISL_ADDR_RAW1     14'h1CCC
`define CISL_ADDR_MASK1    14'h1CE0
`define CISL_ADDR_MASK2    14'h1CE4

// ----------------------------------------------------------------
// Implemented bits, edge sensitivity and mask reset values
// ----------------------------------------------------------------
`define CISL_IMPL1         16'h07A1
`define CISL_IMPL2         16'hDBE0
`define CISL_BOTH1         16'h07A1
`define CISL_BOTH2         16'h81E0
`define CISL_RISE2         16'h5A00
`define CISL_MASK1_RST     16'h07FF
`define CISL_MASK2_RST     16'hFFFF

`endif

// File: cisl_pkg.sv
package cisl_pkg;
  typedef logic [15:0] cisl_word_t;
  typedef struct packed {
    cisl_word_t first;
    cisl_word_t second;
  } cisl_src_s;
  typedef enum logic [1:0] {
    CISL_IDLE,
    CISL_ACCESS
  } cisl_phase_e;
endpackage

// File: cisl_edge_latch.sv
`timescale 1ns/1ns
`include "cisl_defines.svh"
module cisl_edge_latch #(
  parameter int          W    = 16,
  parameter logic [15:0] IMPL = 16'h0000,
  parameter logic [15:0] BOTH = 16'h0000,
  parameter logic [15:0] RISE = 16'h0000
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] src_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flag_o,
  output logic      [W-1:0] raw_o
);
  logic [W-1:0] prev;
  logic [W-1:0] next_flag;
  logic [W-1:0] hit;

  // ----------------------------------------------------------------
  // Per-bit edge detect
  // ----------------------------------------------------------------
  for (genvar b = 0; b < W; b++) begin : g_bit
    assign hit[b] = IMPL[b] & ((BOTH[b] & (src_i[b] ^ prev[b])) |
                               (RISE[b] & src_i[b] & ~prev[b]));
  end

  // Set beats a same-cycle clear
  always_comb begin
    next_flag = (flag_o & ~clr_i) | hit;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev   <= '0;
      flag_o <= '0;
    end else if (ce_i) begin
      prev   <= src_i;
      flag_o <= next_flag;
    end
  end

  assign raw_o = src_i & IMPL[W-1:0];

  a_edge_sets_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && (hit != '0) |=> ((flag_o & $past(hit)) == $past(hit)))
    else $error("edge event not latched");
endmodule // cisl_edge_latch

// File: cisl_irq_top.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
`include "cisl_defines.svh"
module cisl_irq_top (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              ce_i,
  input  wire cisl_pkg::cisl_src_s src_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [13:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic                   irq_o
);
  import cisl_pkg::*;

  cisl_word_t  flag1, flag2, raw1, raw2, clr1, clr2;
  cisl_word_t  mask1, mask2, next_mask1, next_mask2;
  logic [31:0] next_prdata;
  logic        next_slverr;
  logic        next_irq;
  logic        wr_en;
  logic        hit_addr;
  cisl_phase_e phase, next_phase;

  // ----------------------------------------------------------------
  // Flag latches
  // ----------------------------------------------------------------
  cisl_edge_latch #(
    .W    (16),
    .IMPL (`CISL_IMPL1),
    .BOTH (`CISL_BOTH1),
    .RISE (16'h0000)
  ) u_first (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .src_i    (src_i.first),
    .clr_i    (clr1),
    .flag_o   (flag1),
    .raw_o    (raw1)
  );

  // Bits 9 and 11 rising only, 12 and 14 too
  cisl_edge_latch #(
    .W    (16),
    .IMPL (`CISL_IMPL2),
    .BOTH (`CISL_BOTH2),
    .RISE (`CISL_RISE2)
  ) u_second (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .src_i    (src_i.second),
    .clr_i    (clr2),
    .flag_o   (flag2),
    .raw_o    (raw2)
  );

  // ----------------------------------------------------------------
  // APB slave, one wait-free access phase
  // ----------------------------------------------------------------
  // No wait states, flags and masks answer from flops already settled, raw values straight from src_i
  assign wr_en    = psel_i & penable_i & pwrite_i;
  assign pready_o = 1'b1;
  // Unmapped offsets answer with an error, writes there are dropped
  assign hit_addr = (paddr_i == `CISL_ADDR_FLAGS1) || (paddr_i == `CISL_ADDR_FLAGS2) ||
                    (paddr_i == `CISL_ADDR_RAW1) || (paddr_i == `CISL_ADDR_RAW2) ||
                    (paddr_i == `CISL_ADDR_MASK1) || (paddr_i == `CISL_ADDR_MASK2);

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Only the low half is stored, the registers are 16 bits wide
  always_comb begin
    clr1 = '0;
    clr2 = '0;
    next_mask1 = mask1;
    next_mask2 = mask2;
    if (wr_en && paddr_i == `CISL_ADDR_FLAGS1) begin
      clr1 = pwdata_i[15:0];
    end else if (wr_en && paddr_i == `CISL_ADDR_FLAGS2) begin
      clr2 = pwdata_i[15:0];
    end else if (wr_en && paddr_i == `CISL_ADDR_MASK1) begin
      next_mask1 = pwdata_i[15:0];
    end else if (wr_en && paddr_i == `CISL_ADDR_MASK2) begin
      next_mask2 = pwdata_i[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Caught at setup so the data stands through the whole access phase
  always_comb begin
    next_prdata = prdata_o;
    next_slverr = 1'b0;
    next_phase  = CISL_IDLE;
    case (phase)
      CISL_IDLE: begin
        if (psel_i && !penable_i) begin
          next_phase = CISL_ACCESS;
          if (paddr_i == `CISL_ADDR_FLAGS1) begin
            next_prdata = {16'h0000, flag1};
          end else if (paddr_i == `CISL_ADDR_FLAGS2) begin
            next_prdata = {16'h0000, flag2};
          end else if (paddr_i == `CISL_ADDR_RAW1) begin
            next_prdata = {16'h0000, raw1};
          end else if (paddr_i == `CISL_ADDR_RAW2) begin
            next_prdata = {16'h0000, raw2};
          end else if (paddr_i == `CISL_ADDR_MASK1) begin
            next_prdata = {16'h0000, mask1};
          end else if (paddr_i == `CISL_ADDR_MASK2) begin
            next_prdata = {16'h0000, mask2};
          end else begin
            next_prdata = 32'h00000000;
          end
          next_slverr = ~hit_addr;
        end
      end
      default: begin
        next_phase = CISL_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  always_comb begin
    next_irq = |((flag1 & ~mask1) | (flag2 & ~mask2));
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask1     <= `CISL_MASK1_RST;
      mask2     <= `CISL_MASK2_RST;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
      phase     <= CISL_IDLE;
    end else if (ce_i) begin
      mask1     <= next_mask1;
      mask2     <= next_mask2;
      prdata_o  <= next_prdata;
      pslverr_o <= next_slverr;
      phase     <= next_phase;
    end
  end

  // Level output, combinational so a clear drops it at once
  assign irq_o = next_irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_irq_masked: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (((flag1 & ~mask1) == 16'h0000) && ((flag2 & ~mask2) == 16'h0000)) |-> !irq_o)
    else $error("irq high with no unmasked flag");
  a_irq_unmasked: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ((flag2 & ~mask2) != 16'h0000) |-> irq_o)
    else $error("unmasked flag did not raise irq");
  a_irq_first: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ((flag1 & ~mask1) != 16'h0000) |-> irq_o)
    else $error("unmasked first flag did not raise irq");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && !(wr_en && paddr_i == `CISL_ADDR_FLAGS1) && flag1[5] |=> flag1[5])
    else $error("flag dropped without clear");
  a_zero_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && wr_en && (paddr_i == `CISL_ADDR_FLAGS1) && !pwdata_i[0] && flag1[0]
    |=> flag1[0])
    else $error("zero write cleared a flag");
  a_clear_works: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && wr_en && paddr_i == `CISL_ADDR_FLAGS2 && pwdata_i[14] && !src_i.second[14]
    |=> !flag2[14])
    else $error("write one did not clear");
  a_pin_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && $past(ce_i) && $past(arst_n_i) && wr_en && (paddr_i == `CISL_ADDR_FLAGS1) &&
    pwdata_i[10] && $stable(src_i.first[10])
    |=> !flag1[10])
    else $error("write one did not clear pin flag");
  a_fall_only_rise: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && $fell(src_i.second[12]) && !flag2[12] && $past(ce_i) |=> !flag2[12])
    else $error("falling edge set rising-only flag");
  a_servo_rise: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && $rose(src_i.second[14]) && $past(ce_i) |=> flag2[14])
    else $error("servo done rise missed");
  a_drc2_rise: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && $rose(src_i.second[11]) && $past(ce_i) |=> flag2[11])
    else $error("activity rise missed");
  a_drc1_fall: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && $fell(src_i.second[9]) && !flag2[9] && $past(ce_i) |=> !flag2[9])
    else $error("activity fall set flag");
  a_drc1_rise: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && $rose(src_i.second[9]) && $past(ce_i) |=> flag2[9])
    else $error("first port activity rise missed");
  a_warn_fall: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && $fell(src_i.second[15]) && $past(ce_i) && $past(arst_n_i) |=> flag2[15])
    else $error("warning fall missed");
  a_jack_fall: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && $fell(src_i.first[5]) && $past(ce_i) && $past(arst_n_i) |=> flag1[5])
    else $error("jack fall missed");
  a_pin_rise: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && $rose(src_i.first[0]) && $past(ce_i) |=> flag1[0])
    else $error("pin one rise missed");
  a_mask_holds: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !(ce_i && wr_en && (paddr_i == `CISL_ADDR_MASK1)) |=> $stable(mask1))
    else $error("first mask changed without write");
  a_mask2_holds: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !(ce_i && wr_en && (paddr_i == `CISL_ADDR_MASK2)) |=> $stable(mask2))
    else $error("second mask changed without write");
  a_raw_level: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ce_i && psel_i && !penable_i && (paddr_i == `CISL_ADDR_RAW2) |=> prdata_o[15:14] == $past(src_i.second[15:14]))
    else $error("raw status not following source");
endmodule // cisl_irq_top

// File: cisl_src_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Source levels as the core logic shows them
// ----------------------------------------
module cisl_src_model (
  input  wire logic                clk_i,
  input  wire cisl_pkg::cisl_src_s req_i,
  output cisl_pkg::cisl_src_s      src_o
);
  import cisl_pkg::*;
  // Levels start low, changes only at rising edges like real core logic
  initial src_o = '0;
  always @(posedge clk_i) begin
    src_o <= req_i;
  end
endmodule // cisl_src_model

// File: codec_interrupt_status_latch_tb_top.sv
`timescale 1ns/1ns
`include "cisl_defines.svh"
module codec_interrupt_status_latch_tb_top;
  import cisl_pkg::*;
  logic        clk_i     = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic        ce_i      = 1'b1;
  logic [13:0] paddr_i   = 14'h0000;
  logic [31:0] pwdata_i  = 32'h00000000;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        irq_o;
  cisl_src_s   req       = '0;
  cisl_src_s   src;
  int          n_mismatch  = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  logic [31:0] rd;
  logic        err;
  // ----------------------------------------
  // Design and partner
  // ----------------------------------------
  cisl_src_model PM (.clk_i(clk_i), .req_i(req), .src_o(src));
  cisl_irq_top DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .src_i(src),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o));
  initial forever #50 clk_i = ~clk_i;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Slave may stretch the access phase; the wait ends once pready_o is high
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input string nm, input logic [13:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(nm, {16'h0000, e}, rd);
  endtask
  task automatic drive_src(input logic [15:0] f, input logic [15:0] s);
    req <= '{first: f, second: s};
    repeat (4) @(posedge clk_i);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    rdchk("mask1", `CISL_ADDR_MASK1, 16'h07FF);
    rdchk("mask2", `CISL_ADDR_MASK2, 16'hFFFF);
    rdchk("flags1", `CISL_ADDR_FLAGS1, 16'h0000);
    chk("irq", 32'h0, {31'h0, irq_o});
    apb(1'b0, 14'h1CD0, 32'h00000000);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 14'h1CD0, 32'h00000000);
    rdchk("mask1 kept", `CISL_ADDR_MASK1, 16'h07FF);
    $display("test reset done");
  endtask
  task automatic test_rise_only();
    drive_src(16'h0000, 16'h5A00);
    rdchk("flags2 rise", `CISL_ADDR_FLAGS2, 16'h5A00);
    rdchk("raw2", `CISL_ADDR_RAW2, 16'h5A00);
    apb(1'b1, `CISL_ADDR_FLAGS2, 32'h0000FFFF);
    // Falling sources must leave these flags clear
    drive_src(16'h0000, 16'h0000);
    rdchk("flags2 fall", `CISL_ADDR_FLAGS2, 16'h0000);
    $display("test rise only done");
  endtask
  task automatic test_both_edges();
    drive_src(16'h07A1, 16'h81E0);
    rdchk("flags1 rise", `CISL_ADDR_FLAGS1, 16'h07A1);
    rdchk("flags2 rise", `CISL_ADDR_FLAGS2, 16'h81E0);
    rdchk("raw1", `CISL_ADDR_RAW1, 16'h07A1);
    apb(1'b1, `CISL_ADDR_FLAGS1, 32'h00000000);
    rdchk("flags1 zero wr", `CISL_ADDR_FLAGS1, 16'h07A1);
    apb(1'b1, `CISL_ADDR_FLAGS1, 32'h000007A1);
    apb(1'b1, `CISL_ADDR_FLAGS2, 32'h000081E0);
    rdchk("flags1 clr", `CISL_ADDR_FLAGS1, 16'h0000);
    rdchk("flags2 clr", `CISL_ADDR_FLAGS2, 16'h0000);
    drive_src(16'h0000, 16'h0000);
    rdchk("flags1 fall", `CISL_ADDR_FLAGS1, 16'h07A1);
    rdchk("flags2 fall", `CISL_ADDR_FLAGS2, 16'h81E0);
    $display("test both edges done");
  endtask
  task automatic test_irq();
    chk("irq masked", 32'h0, {31'h0, irq_o});
    apb(1'b1, `CISL_ADDR_MASK1, 32'h000007FE);
    repeat (2) @(posedge clk_i);
    chk("irq pin one", 32'h1, {31'h0, irq_o});
    apb(1'b1, `CISL_ADDR_FLAGS1, 32'h00000001);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    apb(1'b1, `CISL_ADDR_MASK2, 32'h00007FFF);
    repeat (2) @(posedge clk_i);
    chk("irq thermal", 32'h1, {31'h0, irq_o});
    apb(1'b1, `CISL_ADDR_FLAGS2, 32'h00008000);
    repeat (2) @(posedge clk_i);
    chk("irq thermal clr", 32'h0, {31'h0, irq_o});
    $display("test irq done");
  endtask
  task automatic test_mid_reset();
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rdchk("flags1 rst", `CISL_ADDR_FLAGS1, 16'h0000);
    rdchk("flags2 rst", `CISL_ADDR_FLAGS2, 16'h0000);
    rdchk("mask1 rst", `CISL_ADDR_MASK1, 16'h07FF);
    rdchk("mask2 rst", `CISL_ADDR_MASK2, 16'hFFFF);
    chk("irq rst", 32'h0, {31'h0, irq_o});
    $display("test mid reset done");
  endtask
  task automatic test_freeze();
    apb(1'b1, `CISL_ADDR_MASK1, 32'h000007DF);
    // Enable low holds the edge history, so the jack rise waits for it
    ce_i <= 1'b0;
    drive_src(16'h0020, 16'h0000);
    chk("irq frozen", 32'h0, {31'h0, irq_o});
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("irq thawed", 32'h1, {31'h0, irq_o});
    rdchk("flags1 thawed", `CISL_ADDR_FLAGS1, 16'h0020);
    $display("test freeze done");
  endtask
  // ----------------------------------------
  // Sequence and timeout
  // ----------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    test_reset();
    test_rise_only();
    test_both_edges();
    test_irq();
    test_mid_reset();
    test_freeze();
    print_verdict();
  end
endmodule // codec_interrupt_status_latch_tb_top
